// file: hdl/fps_pkg.sv
// Constants, codes and types for the flash command controller
package fps_pkg;
	localparam int unsigned ADDR_W = 24;
	localparam int unsigned DQ_W   = 16;
	// Pin timing, figures in ns, cycles rounded up at the clock rate
	localparam int unsigned CLK_MHZ   = 100;
	localparam int unsigned T_WE_NS   = 70;
	localparam int unsigned T_RD_NS   = 120;
	localparam int unsigned T_HOLD_NS = 20;
	localparam int unsigned SYNC_CYC  = 2;
	localparam logic [7:0] WE_CYC   = 8'((T_WE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [7:0] RD_CYC   = 8'((T_RD_NS * CLK_MHZ + 999) / 1000 + SYNC_CYC);
	localparam logic [7:0] HOLD_CYC = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);
	// Controller operations written to the command register
	localparam logic [3:0] OP_READ_ARRAY = 4'h0;
	localparam logic [3:0] OP_READ_STAT  = 4'h1;
	localparam logic [3:0] OP_CLEAR_STAT = 4'h2;
	localparam logic [3:0] OP_PROGRAM    = 4'h3;
	localparam logic [3:0] OP_ERASE_SUSP = 4'h4;
	localparam logic [3:0] OP_ERASE_RES  = 4'h5;
	localparam logic [3:0] OP_PROG_SUSP  = 4'h6;
	localparam logic [3:0] OP_PROG_RES   = 4'h7;
	localparam logic [3:0] OP_SET_LOCK   = 4'h8;
	localparam logic [3:0] OP_CONFIG     = 4'h9;
	// Flash command bytes
	localparam logic [7:0] FC_PROGRAM     = 8'h40;
	localparam logic [7:0] FC_PROGRAM_ALT = 8'h10;
	localparam logic [7:0] FC_READ_ARRAY  = 8'hFF;
	localparam logic [7:0] FC_READ_STAT   = 8'h70;
	localparam logic [7:0] FC_CLEAR_STAT  = 8'h50;
	localparam logic [7:0] FC_SUSPEND     = 8'hB0;
	localparam logic [7:0] FC_RESUME      = 8'hD0;
	localparam logic [7:0] FC_LOCK_SETUP  = 8'h60;
	localparam logic [7:0] FC_LOCK_CONF   = 8'h01;
	localparam logic [7:0] FC_CONFIG      = 8'hB8;
	// Flash status byte bit positions
	localparam int unsigned SB_READY = 7;
	localparam int unsigned SB_ESUSP = 6;
	localparam int unsigned SB_EFAIL = 5;
	localparam int unsigned SB_PFAIL = 4;
	localparam int unsigned SB_VLOW  = 3;
	localparam int unsigned SB_PSUSP = 2;
	localparam int unsigned SB_LOCKV = 1;
	localparam logic [7:0] SB_FAIL_MASK = 8'h3A;
	localparam logic [7:0] SB_RESET     = 8'h80;
	// APB register offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_ADDR   = 8'h08;
	localparam logic [7:0] OFS_DATA   = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	// Control register fields
	localparam int unsigned CTL_RUN  = 0;
	localparam int unsigned CTL_WP   = 1;
	localparam int unsigned CTL_ALT  = 2;
	localparam logic [2:0] CTL_RESET = 3'h0;
	typedef enum logic [3:0] {
		FPS_P_IDLE = 4'b0001,
		FPS_P_SET  = 4'b0010,
		FPS_P_STB  = 4'b0100,
		FPS_P_HLD  = 4'b1000
	} fps_phase_t;
	typedef enum logic [3:0] {
		FPS_S_IDLE = 4'b0001,
		FPS_S_W1   = 4'b0010,
		FPS_S_W2   = 4'b0100,
		FPS_S_RD   = 4'b1000
	} fps_state_t;
endpackage

// file: hdl/fps_cyc_if.sv
// Request and answer bundle between sequencer and pin cycle engine
`timescale 1ns/10ps
`default_nettype none
interface fps_cyc_if;
	logic                      req;
	logic                      wr;
	logic [fps_pkg::ADDR_W-1:0] addr;
	logic [fps_pkg::DQ_W-1:0]   wdata;
	logic                      done;
	logic [fps_pkg::DQ_W-1:0]   rdata;
	modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
	modport cyc (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// file: hdl/fps_flash_cycle.sv
// One flash bus cycle: chip select, write or output strobe, hold
`timescale 1ns/10ps
`default_nettype none
module fps_flash_cycle (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	fps_cyc_if.cyc                          bus,
	output var  logic [fps_pkg::ADDR_W-1:0] flash_addr_q,
	output var  logic [fps_pkg::DQ_W-1:0]   flash_dq_o_q,
	output var  logic                       flash_dq_oe_q,
	input  wire logic [fps_pkg::DQ_W-1:0]   flash_dq_i,
	output var  logic                       flash_ce_n_q,
	output var  logic                       flash_we_n_q,
	output var  logic                       flash_oe_n_q
);
	fps_pkg::fps_phase_t        phase_q;
	logic [7:0]                 cnt_q;
	logic                       wr_q;
	logic                       done_q;
	logic [fps_pkg::DQ_W-1:0]   dq_s1_q;
	logic [fps_pkg::DQ_W-1:0]   dq_s2_q;
	logic [fps_pkg::DQ_W-1:0]   rdata_q;
	logic                       last;

	assign last      = (cnt_q == 8'h01);
	assign bus.done  = done_q;
	assign bus.rdata = rdata_q;

	// Data pins are asynchronous; read strobe covers the two sync stages
	always_ff @(posedge clk)
	begin
		dq_s1_q <= flash_dq_i;
		dq_s2_q <= dq_s1_q;
	end

	// Phase sequencer; a request seen with done high is the old one, so ignored
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			phase_q <= fps_pkg::FPS_P_IDLE;
			cnt_q   <= 8'h00;
			wr_q    <= 1'b0;
			done_q  <= 1'b0;
		end
		else
		begin
			done_q <= (phase_q == fps_pkg::FPS_P_HLD) && last;
			case (phase_q)
				fps_pkg::FPS_P_IDLE:
					if (bus.req && !done_q)
					begin
						phase_q <= fps_pkg::FPS_P_SET;
						wr_q    <= bus.wr;
					end
				fps_pkg::FPS_P_SET:
				begin
					phase_q <= fps_pkg::FPS_P_STB;
					cnt_q   <= wr_q ? fps_pkg::WE_CYC : fps_pkg::RD_CYC;
				end
				fps_pkg::FPS_P_STB:
					if (last)
					begin
						phase_q <= fps_pkg::FPS_P_HLD;
						cnt_q   <= fps_pkg::HOLD_CYC;
					end
					else
						cnt_q <= cnt_q - 8'h01;
				fps_pkg::FPS_P_HLD:
					if (last)
						phase_q <= fps_pkg::FPS_P_IDLE;
					else
						cnt_q <= cnt_q - 8'h01;
				default:
					phase_q <= fps_pkg::FPS_P_IDLE;
			endcase
		end
	end

	// Pin drive; the flash latches address and data on the rising write strobe
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			flash_addr_q  <= '0;
			flash_dq_o_q  <= '0;
			flash_dq_oe_q <= 1'b0;
			flash_ce_n_q  <= 1'b1;
			flash_we_n_q  <= 1'b1;
			flash_oe_n_q  <= 1'b1;
			rdata_q       <= '0;
		end
		else
		begin
			if (phase_q == fps_pkg::FPS_P_IDLE && bus.req && !done_q)
			begin
				flash_addr_q  <= bus.addr;
				flash_dq_o_q  <= bus.wdata;
				flash_dq_oe_q <= bus.wr;
				flash_ce_n_q  <= 1'b0;
			end
			if (phase_q == fps_pkg::FPS_P_SET)
			begin
				flash_we_n_q <= !wr_q;
				flash_oe_n_q <= wr_q;
			end
			if (phase_q == fps_pkg::FPS_P_STB && last)
			begin
				flash_we_n_q <= 1'b1;
				flash_oe_n_q <= 1'b1;
				if (!wr_q)
					rdata_q <= dq_s2_q;
			end
			if (phase_q == fps_pkg::FPS_P_HLD && last)
			begin
				flash_ce_n_q  <= 1'b1;
				flash_dq_oe_q <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/fps_pin_watch.sv
// Status pin watcher: synchroniser, level and pulse counter
`timescale 1ns/10ps
`default_nettype none
module fps_pin_watch (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       status_output_pin,
	input  wire logic       pulse_mode,
	output var  logic       level_q,
	output var  logic [7:0] pulse_cnt_q
);
	logic s1_q;
	logic prev_q;

	// Two stages before use; level_q is the second stage
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			s1_q    <= 1'b1;
			level_q <= 1'b1;
		end
		else
		begin
			s1_q    <= status_output_pin;
			level_q <= s1_q;
		end
	end

	// Count low pulses only in pulse mode, where each marks one completion
	// Edge taken after the second stage; the first may still be settling
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			prev_q      <= 1'b1;
			pulse_cnt_q <= 8'h00;
		end
		else
		begin
			prev_q <= level_q;
			if (pulse_mode && prev_q && !level_q)
				pulse_cnt_q <= pulse_cnt_q + 8'h01;
		end
	end
endmodule
`default_nettype wire

// file: hdl/fps_ctrl.sv
// Flash command controller top: APB registers and command sequencer
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module fps_ctrl (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [7:0]                 paddr,
	input  wire logic [31:0]                pwdata,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	output var  logic [fps_pkg::ADDR_W-1:0] flash_addr,
	output var  logic [fps_pkg::DQ_W-1:0]   flash_dq_o,
	output var  logic                       flash_dq_oe,
	input  wire logic [fps_pkg::DQ_W-1:0]   flash_dq_i,
	output var  logic                       flash_ce_n,
	output var  logic                       flash_we_n,
	output var  logic                       flash_oe_n,
	output var  logic                       reset_powerdown_pin_n,
	output var  logic                       write_protect_pin,
	input  wire logic                       status_output_pin
);
	fps_cyc_if cyc ();

	fps_pkg::fps_state_t        state_q;
	logic [2:0]                 ctrl_q;
	logic [fps_pkg::ADDR_W-1:0] addr_q;
	logic [fps_pkg::DQ_W-1:0]   data_q;
	logic [fps_pkg::DQ_W-1:0]   rdata_q;
	logic [7:0]                 sr_q;
	logic [3:0]                 op_q;
	logic                       refused_q;
	logic [1:0]                 config_q;
	logic                       has2_q;
	logic                       rd_q;
	logic                       poll_q;
	logic                       stat_q;
	logic [fps_pkg::DQ_W-1:0]   w2_q;
	logic                       req_q;
	logic                       wr_q;
	logic [fps_pkg::DQ_W-1:0]   wdata_q;
	logic                       pin_level;
	logic [7:0]                 pulse_cnt;
	logic                       acc;
	logic                       cmd_wr;
	logic                       ok;
	logic                       mapped;
	logic [3:0]                 new_op;

	// Host-side gate on what the flash may be sent now
	function automatic logic fps_allowed(input logic [3:0] op, input logic [7:0] sr);
		logic res;
		res = 1'b1;
		if (sr[fps_pkg::SB_PSUSP])
			res = (op == fps_pkg::OP_READ_ARRAY) || (op == fps_pkg::OP_READ_STAT) ||
				(op == fps_pkg::OP_PROG_RES);
		else if (sr[fps_pkg::SB_ESUSP])
			res = (op == fps_pkg::OP_READ_ARRAY) || (op == fps_pkg::OP_PROGRAM) ||
				(op == fps_pkg::OP_PROG_SUSP) || (op == fps_pkg::OP_READ_STAT) ||
				(op == fps_pkg::OP_ERASE_RES);
		else if (op == fps_pkg::OP_CONFIG)
			res = sr[fps_pkg::SB_READY];
		else if (op > fps_pkg::OP_CONFIG)
			res = 1'b0;
		return res;
	endfunction

	assign acc    = psel && penable && pready;
	assign cmd_wr = acc && pwrite && (paddr == fps_pkg::OFS_CMD);
	assign new_op = pwdata[3:0];
	assign ok     = (state_q == fps_pkg::FPS_S_IDLE) && fps_allowed(new_op, sr_q) &&
		ctrl_q[fps_pkg::CTL_RUN];
	assign mapped = (paddr == fps_pkg::OFS_CTRL) || (paddr == fps_pkg::OFS_CMD) ||
		(paddr == fps_pkg::OFS_ADDR) || (paddr == fps_pkg::OFS_DATA) ||
		(paddr == fps_pkg::OFS_STATUS);

	assign cyc.req   = req_q;
	assign cyc.wr    = wr_q;
	assign cyc.addr  = addr_q;
	assign cyc.wdata = wdata_q;

	// APB slave: ready in the first access cycle, read data loaded at setup
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			if (psel && !penable)
			begin
				case (paddr)
					fps_pkg::OFS_CTRL:   prdata <= {29'h0, ctrl_q};
					fps_pkg::OFS_CMD:    prdata <= {26'h0, state_q != fps_pkg::FPS_S_IDLE,
						refused_q, op_q};
					fps_pkg::OFS_ADDR:   prdata <= {8'h00, addr_q};
					fps_pkg::OFS_DATA:   prdata <= {rdata_q, data_q};
					fps_pkg::OFS_STATUS: prdata <= {13'h0, config_q, pulse_cnt,
						pin_level, sr_q};
					default:             prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Software-written registers
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			ctrl_q <= fps_pkg::CTL_RESET;
			addr_q <= '0;
			data_q <= '0;
		end
		else if (acc && pwrite)
		begin
			if (paddr == fps_pkg::OFS_CTRL)
				ctrl_q <= pwdata[2:0];
			if (paddr == fps_pkg::OFS_ADDR && state_q == fps_pkg::FPS_S_IDLE)
				addr_q <= pwdata[fps_pkg::ADDR_W-1:0];
			if (paddr == fps_pkg::OFS_DATA && state_q == fps_pkg::FPS_S_IDLE)
				data_q <= pwdata[fps_pkg::DQ_W-1:0];
		end
	end

	// Pin levels for reset/power-down and write protect come from flops
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			reset_powerdown_pin_n <= 1'b0;
			write_protect_pin     <= 1'b0;
		end
		else
		begin
			reset_powerdown_pin_n <= ctrl_q[fps_pkg::CTL_RUN];
			write_protect_pin     <= ctrl_q[fps_pkg::CTL_WP];
		end
	end

	// Mirror of the status pin mode; power-down drops it back to level mode
	// A code with reserved bits set leaves the flash's mode alone, so the mirror too
	always_ff @(posedge clk)
	begin
		if (!resetn || !ctrl_q[fps_pkg::CTL_RUN])
			config_q <= 2'b00;
		else if (cmd_wr && ok && new_op == fps_pkg::OP_CONFIG && data_q[7:2] == 6'h00)
			config_q <= data_q[1:0];
	end

	// Last command word and whether it was turned away
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			op_q      <= fps_pkg::OP_READ_ARRAY;
			refused_q <= 1'b0;
		end
		else if (cmd_wr)
		begin
			op_q      <= new_op;
			refused_q <= !ok;
		end
	end

	// Sequencer: first write, optional second write, then optional read or status poll
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_q <= fps_pkg::FPS_S_IDLE;
			req_q   <= 1'b0;
			wr_q    <= 1'b0;
			wdata_q <= '0;
			has2_q  <= 1'b0;
			rd_q    <= 1'b0;
			poll_q  <= 1'b0;
			stat_q  <= 1'b0;
			w2_q    <= '0;
		end
		else
		begin
			case (state_q)
				fps_pkg::FPS_S_IDLE:
					if (cmd_wr && ok)
					begin
						state_q <= fps_pkg::FPS_S_W1;
						req_q   <= 1'b1;
						wr_q    <= 1'b1;
						has2_q  <= 1'b0;
						rd_q    <= 1'b1;
						poll_q  <= 1'b0;
						stat_q  <= 1'b1;
						w2_q    <= data_q;
						case (new_op)
							fps_pkg::OP_READ_ARRAY:
							begin
								wdata_q <= {8'h00, fps_pkg::FC_READ_ARRAY};
								stat_q  <= 1'b0;
							end
							fps_pkg::OP_READ_STAT:
								wdata_q <= {8'h00, fps_pkg::FC_READ_STAT};
							fps_pkg::OP_CLEAR_STAT:
							begin
								wdata_q <= {8'h00, fps_pkg::FC_CLEAR_STAT};
								rd_q    <= 1'b0;
							end
							fps_pkg::OP_PROGRAM:
							begin
								wdata_q <= {8'h00, ctrl_q[fps_pkg::CTL_ALT] ?
									fps_pkg::FC_PROGRAM_ALT : fps_pkg::FC_PROGRAM};
								has2_q  <= 1'b1;
								poll_q  <= 1'b1;
							end
							fps_pkg::OP_ERASE_SUSP, fps_pkg::OP_PROG_SUSP:
							begin
								wdata_q <= {8'h00, fps_pkg::FC_SUSPEND};
								poll_q  <= 1'b1;
							end
							fps_pkg::OP_ERASE_RES, fps_pkg::OP_PROG_RES:
								wdata_q <= {8'h00, fps_pkg::FC_RESUME};
							fps_pkg::OP_SET_LOCK:
							begin
								wdata_q <= {8'h00, fps_pkg::FC_LOCK_SETUP};
								w2_q    <= {8'h00, fps_pkg::FC_LOCK_CONF};
								has2_q  <= 1'b1;
								poll_q  <= 1'b1;
							end
							fps_pkg::OP_CONFIG:
							begin
								wdata_q <= {8'h00, fps_pkg::FC_CONFIG};
								w2_q    <= {8'h00, data_q[7:0]};
								has2_q  <= 1'b1;
								rd_q    <= 1'b0;
							end
							default:
								wdata_q <= {8'h00, fps_pkg::FC_READ_STAT};
						endcase
					end
				fps_pkg::FPS_S_W1:
					if (cyc.done)
					begin
						if (has2_q)
						begin
							state_q <= fps_pkg::FPS_S_W2; // same address for the confirm
							wdata_q <= w2_q;
						end
						else if (rd_q)
						begin
							state_q <= fps_pkg::FPS_S_RD;
							wr_q    <= 1'b0;
						end
						else
						begin
							state_q <= fps_pkg::FPS_S_IDLE;
							req_q   <= 1'b0;
						end
					end
				fps_pkg::FPS_S_W2:
					if (cyc.done)
					begin
						if (rd_q)
						begin
							state_q <= fps_pkg::FPS_S_RD;
							wr_q    <= 1'b0;
						end
						else
						begin
							state_q <= fps_pkg::FPS_S_IDLE;
							req_q   <= 1'b0;
						end
					end
				fps_pkg::FPS_S_RD:
					// Polling has no cycle limit; a dead flash leaves busy set
					if (cyc.done && !(poll_q && !cyc.rdata[fps_pkg::SB_READY]))
					begin
						state_q <= fps_pkg::FPS_S_IDLE;
						req_q   <= 1'b0;
					end
				default:
				begin
					state_q <= fps_pkg::FPS_S_IDLE;
					req_q   <= 1'b0;
				end
			endcase
		end
	end

	// Read capture; while busy only the ready bit of a status read is trusted
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			rdata_q <= '0;
			sr_q    <= fps_pkg::SB_RESET;
		end
		else if (state_q == fps_pkg::FPS_S_W1 && cyc.done && op_q == fps_pkg::OP_CLEAR_STAT)
			sr_q <= sr_q & ~fps_pkg::SB_FAIL_MASK;
		else if (state_q == fps_pkg::FPS_S_RD && cyc.done)
		begin
			rdata_q <= cyc.rdata;
			if (stat_q && cyc.rdata[fps_pkg::SB_READY])
				sr_q <= cyc.rdata[7:0];
			else if (stat_q)
				sr_q[fps_pkg::SB_READY] <= 1'b0;
		end
	end

	fps_flash_cycle u_cycle (
		.clk           (clk),
		.resetn        (resetn),
		.bus           (cyc.cyc),
		.flash_addr_q  (flash_addr),
		.flash_dq_o_q  (flash_dq_o),
		.flash_dq_oe_q (flash_dq_oe),
		.flash_dq_i    (flash_dq_i),
		.flash_ce_n_q  (flash_ce_n),
		.flash_we_n_q  (flash_we_n),
		.flash_oe_n_q  (flash_oe_n)
	);

	fps_pin_watch u_pin (
		.clk               (clk),
		.resetn            (resetn),
		.status_output_pin (status_output_pin),
		.pulse_mode        (config_q != 2'b00),
		.level_q           (pin_level),
		.pulse_cnt_q       (pulse_cnt)
	);
endmodule
`default_nettype wire

// file: sim/fps_ctrl_properties.sv
// Assertions on the controller's bus and flash pins
`timescale 1ns/10ps
`default_nettype none
module fps_ctrl_properties (
	input wire logic                       clk, resetn, psel, penable, pready, pslverr,
	input wire logic [fps_pkg::ADDR_W-1:0] flash_addr,
	input wire logic [fps_pkg::DQ_W-1:0]   flash_dq_o,
	input wire logic                       flash_dq_oe, flash_ce_n, flash_we_n, flash_oe_n,
	input wire logic                       reset_powerdown_pin_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic [7:0] oe_low_q;
	// Counts output strobe low time so its length is judged when it ends
	always_ff @(posedge clk)
		oe_low_q <= (!resetn || flash_oe_n) ? 8'h00 : oe_low_q + 8'h01;
	sequence we_low_s;
		!flash_we_n [*7];
	endsequence
	sequence we_latch_s;
		flash_we_n && !flash_ce_n && flash_dq_oe;
	endsequence
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held too long");
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("access phase not answered");
	error_ready_a: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	we_length_a: assert property ($fell(flash_we_n) |-> we_low_s ##1 we_latch_s)
		else $error("write strobe length wrong");
	latch_hold_a: assert property ($rose(flash_we_n) |-> $stable({flash_addr, flash_dq_o}))
		else $error("address or data moved at latch edge");
	read_length_a: assert property ($rose(flash_oe_n) |-> oe_low_q == fps_pkg::RD_CYC)
		else $error("output strobe length wrong");
	strobe_excl_a: assert property (flash_we_n || flash_oe_n)
		else $error("both strobes low");
	read_float_a: assert property (!flash_oe_n |-> !flash_dq_oe)
		else $error("data driven during read");
	cycle_gap_a: assert property ($rose(flash_ce_n) |=> flash_ce_n)
		else $error("no idle cycle between flash cycles");
	pin_reset_a: assert property (@(posedge clk) disable iff (1'b0) !resetn |=> !reset_powerdown_pin_n)
		else $error("flash left out of reset");
endmodule
bind fps_ctrl fps_ctrl_properties u_props (.clk(clk), .resetn(resetn), .psel(psel),
	.penable(penable), .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr),
	.flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
	.flash_we_n(flash_we_n), .flash_oe_n(flash_oe_n),
	.reset_powerdown_pin_n(reset_powerdown_pin_n));
`default_nettype wire

// file: sim/fps_flash_model.sv
// Behavioural flash device answering the controller's pin cycles
`timescale 1ns/10ps
`default_nettype none
module fps_flash_model (
	input  wire logic        clk,
	input  wire logic        ce_n, we_n, oe_n, rp_n, wp, vpp_low,
	input  wire logic [23:0] addr,
	input  wire logic [15:0] dq_w,
	output logic      [15:0] dq_r,
	output logic             sts
);
	logic [7:0]   sr;
	logic [15:0]  mem [64];
	logic [255:0] lock;
	logic [1:0]   pend, p, cfg;
	logic         stat_mode, we_q;
	logic [15:0]  last;
	int           busy, pls;
	// Only the ready bit is trustworthy while busy; a released bus shows junk
	assign dq_r = (!ce_n && !oe_n) ? (stat_mode ? {8'h00, sr[7], sr[7] ? sr[6:0] : 7'h55}
		: mem[addr[5:0]]) : ~last;
	// Level mode follows ready; pulse mode idles high and dips on completion only when cfg[1] is set
	assign sts = (cfg == 2'b00) ? sr[7] : (pls == 0);
	initial
	begin
		foreach (mem[i])
			mem[i] = 16'hFFFF;
		lock = '0;
		last = 16'h0000;
		we_q = 1'b1;
	end
	// The clock paces the timer and samples the strobe; commands act on the rising write strobe
	// Falling edge, so pins never change on the controller's sampling edge
	always @(negedge clk)
	begin
		if (!ce_n && !oe_n)
			last <= dq_r;
		we_q <= we_n;
		if (rp_n !== 1'b1)
		begin
			sr = 8'h80;
			cfg = 2'b00;
			pend = 2'd0;
			busy = 0;
			pls = 0;
			stat_mode = 1'b0;
		end
		else
		begin
			if (pls > 0)
				pls--;
			if (busy > 0 && !sr[2])
			begin
				busy--;
				if (busy == 0)
				begin
					sr[7] = 1'b1;
					pls = cfg[1] ? 25 : 0;
				end
			end
			if (we_n && !we_q && !ce_n)
			begin
				stat_mode = pend != 2'd0 || dq_w[7:0] != 8'hFF;
				p = pend;
				pend = 2'd0;
				case (p)
				2'd1:
					if (vpp_low)
						sr = sr | 8'h18;
					else if (lock[addr[23:16]] && !wp)
						sr = sr | 8'h12;
					else
					begin
						mem[addr[5:0]] = mem[addr[5:0]] & dq_w;
						sr[7] = 1'b0;
						busy = 30;
					end
				2'd2:
					if (dq_w[7:0] != 8'h01)
						sr = sr | 8'h30;
					else if (!wp)
						sr = sr | 8'h12;
					else
						lock[addr[23:16]] = 1'b1;
				2'd3:
					if (dq_w[7:2] != 6'h00)
						sr = sr | 8'h30;
					else
						cfg = dq_w[1:0];
				default:
					case (dq_w[7:0])
					8'h40, 8'h10: pend = 2'd1;
					8'h60: pend = 2'd2;
					8'hB8: pend = 2'd3;
					8'h50: sr = sr & 8'hC5;
					8'hB0: if (busy > 0) sr = sr | 8'h84;
					8'hD0: if (sr[2]) sr = sr & 8'h7B;
					default: ;
					endcase
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// file: sim/flash_program_suspend_lock_cmds_tb_top.sv
// Self-checking bench for the flash command controller
`timescale 1ns/10ps
`default_nettype none
module flash_program_suspend_lock_cmds_tb_top;
	typedef struct packed {
		logic [2:0]  ctl;
		logic [3:0]  op;
		logic [23:0] a;
		logic [15:0] d;
		logic [7:0]  st;
	} fps_row_t;
	// Control, operation, address, data, expected status byte
	localparam fps_row_t ROWS [9] = '{
		'{3'h3, 4'h8, 24'h010000, 16'h0000, 8'h80},
		'{3'h1, 4'h3, 24'h010004, 16'h5555, 8'h92},
		'{3'h3, 4'h3, 24'h010004, 16'h5555, 8'h80},
		'{3'h1, 4'h8, 24'h020000, 16'h0000, 8'h92},
		'{3'h1, 4'h3, 24'h000010, 16'h1234, 8'h80},
		'{3'h5, 4'h3, 24'h000020, 16'h00FF, 8'h80},
		'{3'h1, 4'h6, 24'h000000, 16'h0000, 8'h80},
		'{3'h1, 4'h7, 24'h000000, 16'h0000, 8'h80},
		'{3'h1, 4'h9, 24'h000000, 16'h0004, 8'hB0}
	};
	logic        clk, resetn, psel, penable, pwrite, vpp_low, slverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, dq_oe, ce_n, we_n, oe_n, rp_n, wp, sts;
	logic [23:0] f_addr;
	logic [15:0] dq_o, dq_r, dq_i;
	int          errors, checked;
	// The controller hears its own data while it drives the bus
	assign dq_i = dq_oe ? dq_o : dq_r;
	fps_ctrl dut (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.flash_addr(f_addr), .flash_dq_o(dq_o), .flash_dq_oe(dq_oe), .flash_dq_i(dq_i),
		.flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .reset_powerdown_pin_n(rp_n),
		.write_protect_pin(wp), .status_output_pin(sts));
	fps_flash_model u_flash (.clk(clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .rp_n(rp_n),
		.wp(wp), .vpp_low(vpp_low), .addr(f_addr), .dq_w(dq_o), .dq_r(dq_r), .sts(sts));
	// One APB transfer; an idle edge after it keeps drivers from double assignment
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	// Issue an operation and poll until the sequencer is idle again
	task automatic op(input logic [3:0] o);
		int n;
		n = 0;
		apb(1'b1, fps_pkg::OFS_CMD, {28'h0000000, o});
		do
		begin
			apb(1'b0, fps_pkg::OFS_CMD, 32'h00000000);
			n++;
		end while (rd[5] !== 1'b0 && n < 500);
		// A sequence that never ends counts as a mismatch
		if (rd[5] !== 1'b0)
			errors++;
	endtask
	task automatic load(input logic [2:0] c, input logic [23:0] a, input logic [15:0] d);
		apb(1'b1, fps_pkg::OFS_CTRL, {29'h00000000, c});
		apb(1'b1, fps_pkg::OFS_ADDR, {8'h00, a});
		apb(1'b1, fps_pkg::OFS_DATA, {16'h0000, d});
	endtask
	task automatic rd_status;
		op(4'h1);
		apb(1'b0, fps_pkg::OFS_STATUS, 32'h00000000);
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Watchdog sized well beyond the expected run
	initial
	begin
		#600000;
		errors++;
		report_and_stop();
	end
	initial
	begin
		{resetn, psel, penable, pwrite, vpp_low} = 5'h00;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		errors = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 9; i++)
		begin
			load(ROWS[i].ctl, ROWS[i].a, ROWS[i].d);
			op(4'h2);
			op(ROWS[i].op);
			rd_status();
			check("status", rd[7:0], ROWS[i].st);
		end
		// Second program over old data: ones never return and raise no error
		load(3'h1, 24'h000010, 16'h00FF);
		op(4'h2);
		op(4'h3);
		rd_status();
		check("status", rd[7:0], 32'h80);
		op(4'h0);
		apb(1'b0, fps_pkg::OFS_DATA, 32'h00000000);
		check("array", rd[31:16], 32'h0034);
		// Supply lockout then a locked target: flags pile up until cleared
		vpp_low <= 1'b1;
		op(4'h3);
		vpp_low <= 1'b0;
		load(3'h1, 24'h010008, 16'h0000);
		op(4'h3);
		rd_status();
		check("status", rd[7:0], 32'h9A);
		op(4'h2);
		rd_status();
		check("status", rd[7:0], 32'h80);
		// A command while busy and an undefined one are both refused
		apb(1'b1, fps_pkg::OFS_CMD, 32'h00000003);
		apb(1'b1, fps_pkg::OFS_CMD, 32'h00000001);
		apb(1'b0, fps_pkg::OFS_CMD, 32'h00000000);
		check("refused busy", rd[5:4], 32'h3);
		op(4'h1);
		op(4'hA);
		check("refused op", rd[5:4], 32'h1);
		// Pulse on write completion; the pulse lasts about 250 ns, so wait it out
		load(3'h1, 24'h000000, 16'h0002);
		op(4'h9);
		load(3'h1, 24'h000040, 16'h0F0F);
		op(4'h3);
		repeat (40) @(posedge clk);
		apb(1'b0, fps_pkg::OFS_STATUS, 32'h00000000);
		check("pin", rd[18:8], 32'h403);
		load(3'h1, 24'h000000, 16'h0000);
		op(4'h9);
		apb(1'b0, fps_pkg::OFS_STATUS, 32'h00000000);
		check("mode", rd[18:17], 32'h0);
		load(3'h1, 24'h000000, 16'h0001);
		op(4'h9);
		apb(1'b0, fps_pkg::OFS_STATUS, 32'h00000000);
		check("mode", rd[18:17], 32'h1);
		// Reset in mid-run: registers, pin mode and the unmapped answer
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		apb(1'b0, fps_pkg::OFS_STATUS, 32'h00000000);
		check("status", rd, 32'h00000180);
		apb(1'b0, fps_pkg::OFS_CTRL, 32'h00000000);
		check("ctrl", rd, 32'h00000000);
		apb(1'b0, 8'h40, 32'h00000000);
		check("unmapped", rd, 32'h00000000);
		check("slverr", slverr, 32'h1);
		report_and_stop();
	end
endmodule
`default_nettype wire
